// ==== logic/sphb_pkg.sv ====
// Package of constants and types for the serial peripheral host bridge port
// ==========================================================================
package sphb_pkg;
	localparam int      ADDR_W          = 4;
	localparam int      DATA_W          = 8;
	localparam int      NUM_SEL         = 8;
	localparam int      DIV_W           = 8;
	// Register indices
	localparam logic [3:0] REG_DATA_LO  = 4'h0;
	localparam logic [3:0] REG_DATA_HI  = 4'h1;
	localparam logic [3:0] REG_SELECT   = 4'h2;
	localparam logic [3:0] REG_CLKCTL   = 4'h3;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [3:0] REG_GO_BASE  = 4'h8;
	// Clock control fields
	localparam int      CK_INTEN_BIT    = 7;
	localparam int      CK_SLAVE_BIT    = 6;
	localparam int      CK_WIDE_BIT     = 5;
	localparam int      CK_SOIN_BIT     = 4;
	localparam int      CK_DIV_MSB      = 3;
	// Reset values
	localparam logic [7:0] CLKCTL_RST   = 8'h03;
	localparam logic [7:0] SELECT_RST   = 8'hFF;
	// Timing: master clock up to 20 MHz, serial clock up to 5 MHz
	localparam int      MCLK_MAX_KHZ    = 20000;
	localparam int      SCLK_MAX_KHZ    = 5000;
	localparam int      MIN_HALF_DIV    = MCLK_MAX_KHZ / SCLK_MAX_KHZ / 2;
	localparam int      BITS_SHORT      = 8;
	localparam int      BITS_LONG       = 16;
	// Core edges after reset before the strap synchroniser holds the pin level
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [1:0] {SPHB_IDLE, SPHB_SHIFT, SPHB_DONE} sphb_state_t;
endpackage : sphb_pkg

// ==== logic/sphb_sync.sv ====
// Two-flop synchroniser for one level
module sphb_sync
	import sphb_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Level
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sphb_sync_t;

	sphb_sync_t st;
	sphb_sync_t next_st;

	always_comb begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.s2;
endmodule : sphb_sync

// ==== logic/sphb_serial.sv ====
// Serial link engine on the master clock: divider, shifter, master or slave
module sphb_serial
	import sphb_pkg::*;
(
	// Link clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Control, stable while busy
	input  wire logic        start_tgl,
	input  wire logic [15:0] tx_word,
	input  wire logic        wide,
	input  wire logic        slave,
	input  wire logic        so_in,
	input  wire logic [3:0]  div,
	// Result
	output logic             done_tgl,
	output logic             busy,
	output logic [15:0]      rx_word,
	// Pins
	input  wire logic        sclk_in,
	input  wire logic        sdi,
	input  wire logic        so_pin_in,
	output logic             sclk_out,
	output logic             sdo,
	output logic             sdo_oe
);
	typedef struct packed {
		sphb_state_t  state;
		logic [7:0]   cnt;
		logic [4:0]   bits;
		logic [15:0]  sh;
		logic         sk;
		logic         sk_d;
		logic         start_d;
		logic         done_tgl;
		logic [15:0]  rx;
	} sphb_ser_t;

	sphb_ser_t st;
	sphb_ser_t next_st;
	logic      start_s;
	logic      skin_s;
	logic      rx_bit;
	logic      rise;
	logic      fall;

	sphb_sync u_start (.clk(mclk), .rst(rst), .din(start_tgl), .dout(start_s));
	sphb_sync u_skin  (.clk(mclk), .rst(rst), .din(sclk_in),   .dout(skin_s));

	always_comb begin
		next_st = st;
		rx_bit  = so_in ? so_pin_in : sdi;
		rise    = 1'b0;
		fall    = 1'b0;
		next_st.start_d = start_s;
		next_st.sk_d    = skin_s;
		unique case (st.state)
			SPHB_IDLE: begin
				next_st.sk = 1'b0;
				if (start_s != st.start_d) begin
					next_st.state = SPHB_SHIFT;
					next_st.sh    = wide ? tx_word : {tx_word[7:0], 8'h00};
					next_st.bits  = wide ? 5'(BITS_LONG) : 5'(BITS_SHORT);
					next_st.cnt   = 8'h00;
				end
			end
			SPHB_SHIFT: begin
				if (slave) begin
					rise = skin_s & ~st.sk_d;
					fall = ~skin_s & st.sk_d;
				end else begin
					// Divider from master clock, half period (div+MIN_HALF_DIV)
					if (st.cnt >= 8'(div) + 8'(MIN_HALF_DIV) - 8'h01) begin
						next_st.cnt = 8'h00;
						next_st.sk  = ~st.sk;
						rise        = ~st.sk;
						fall        = st.sk;
					end else begin
						next_st.cnt = st.cnt + 8'h01;
					end
				end
				if (rise) begin
					next_st.rx   = {st.rx[14:0], rx_bit};
					next_st.bits = st.bits - 5'h01;
				end
				if (fall) begin
					next_st.sh = {st.sh[14:0], 1'b0};
					if (st.bits == 5'h00) begin
						next_st.state = SPHB_DONE;
					end
				end
			end
			SPHB_DONE: begin
				next_st.state    = SPHB_IDLE;
				next_st.done_tgl = ~st.done_tgl;
			end
			default: next_st.state = SPHB_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done_tgl = st.done_tgl;
	assign busy     = (st.state != SPHB_IDLE);
	assign rx_word  = st.rx;
	assign sclk_out = st.sk;
	assign sdo      = st.sh[15];
	assign sdo_oe   = ~so_in;
endmodule : sphb_serial

// ==== logic/sphb_port.sv ====
// Host parallel port of the serial peripheral bridge, top level
module sphb_port
	import sphb_pkg::*;
(
	// Core clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Serial link clock source
	input  wire logic        master_clock_in,
	// Host control pins
	input  wire logic        reset_n,
	input  wire logic        dev_select_n,
	input  wire logic        addr_strobe_bus_type,
	input  wire logic        read_or_data_strobe,
	input  wire logic        write_or_dir,
	input  wire logic [3:0]  addr_in,
	// Shared bus, three signals
	input  wire logic [7:0]  shared_addr_data_bus_in,
	output logic [7:0]       shared_addr_data_bus_out,
	output logic             shared_addr_data_bus_oe,
	// Strap and interrupt pin
	input  wire logic        bus_format_strap_irq_in,
	output logic             bus_format_strap_irq_out,
	output logic             bus_format_strap_irq_oe,
	// Serial pins
	output logic             serial_clock_out,
	input  wire logic        serial_clock_in,
	input  wire logic        serial_data_in,
	input  wire logic        serial_data_out_in,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	// Peripheral selects
	input  wire logic [3:0]  lower_periph_selects_in,
	output logic [3:0]       lower_periph_selects,
	output logic [3:0]       lower_periph_selects_oe,
	output logic [3:0]       upper_periph_selects,
	output logic [3:0]       upper_periph_selects_oe,
	// Strap result
	output logic             muxed_mode
);
	typedef struct packed {
		logic        strapped;
		logic        muxed;
		logic [3:0]  addr;
		logic        as_d;
		logic        rd_d;
		logic        wr_d;
		logic [7:0]  dlo;
		logic [7:0]  dhi;
		logic [7:0]  sel;
		logic [7:0]  clkctl;
		logic [7:0]  rdata;
		logic        drive;
		logic        start_tgl;
		logic        done_d;
		logic        done_flag;
		logic        hw_sel;
		logic [2:0]  hw_idx;
		logic        busy_d;
		logic [1:0]  strap_wait;
	} sphb_port_t;

	sphb_port_t  st;
	sphb_port_t  next_st;
	logic        prst;
	logic        rst_n_s;
	logic        strap_s;
	logic        cs_s;
	logic        as_s;
	logic        rdds_s;
	logic        wr_s;
	logic [3:0]  a_s;
	logic [7:0]  ad_s;
	logic        done_s;
	logic        busy_s;
	logic        done_tgl;
	logic        ser_busy;
	logic [15:0] rx_word;
	logic [3:0]  addr_now;
	logic        rd_act;
	logic        wr_act;
	logic        rd_edge;
	logic        wr_edge;
	logic [7:0]  cs_lines;

	sphb_sync u_rst  (.clk(core_clk), .rst(rst), .din(~reset_n),                .dout(rst_n_s));
	sphb_sync u_strp (.clk(core_clk), .rst(rst), .din(bus_format_strap_irq_in), .dout(strap_s));
	sphb_sync u_ce   (.clk(core_clk), .rst(rst), .din(~dev_select_n),           .dout(cs_s));
	sphb_sync u_as   (.clk(core_clk), .rst(rst), .din(addr_strobe_bus_type),    .dout(as_s));
	sphb_sync u_rd   (.clk(core_clk), .rst(rst), .din(read_or_data_strobe),     .dout(rdds_s));
	sphb_sync u_wr   (.clk(core_clk), .rst(rst), .din(write_or_dir),            .dout(wr_s));
	sphb_sync u_done (.clk(core_clk), .rst(rst), .din(done_tgl),                .dout(done_s));
	sphb_sync u_busy (.clk(core_clk), .rst(rst), .din(ser_busy),                .dout(busy_s));

	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_ad
			sphb_sync u_ad (.clk(core_clk), .rst(rst), .din(shared_addr_data_bus_in[gi]),
				.dout(ad_s[gi]));
		end
		for (gi = 0; gi < ADDR_W; gi++) begin : g_a
			sphb_sync u_a (.clk(core_clk), .rst(rst), .din(addr_in[gi]), .dout(a_s[gi]));
		end
	endgenerate

	// Reset pin low gives the same state as power-on reset
	assign prst = rst | rst_n_s;

	// Serial engine runs in the link clock domain
	sphb_serial u_ser (
		.mclk      (master_clock_in),
		.rst       (prst),
		.start_tgl (st.start_tgl),
		.tx_word   ({st.dhi, st.dlo}),
		.wide      (st.clkctl[CK_WIDE_BIT]),
		.slave     (st.clkctl[CK_SLAVE_BIT]),
		.so_in     (st.clkctl[CK_SOIN_BIT]),
		.div       (st.clkctl[CK_DIV_MSB:0]),
		.done_tgl  (done_tgl),
		.busy      (ser_busy),
		.rx_word   (rx_word),
		.sclk_in   (serial_clock_in),
		.sdi       (serial_data_in),
		.so_pin_in (serial_data_out_in),
		.sclk_out  (serial_clock_out),
		.sdo       (serial_data_out),
		.sdo_oe    (serial_data_out_oe)
	);

	// ==========================================================================
	// Host strobe decode
	always_comb begin
		addr_now = st.muxed ? st.addr : a_s;
		if (!st.muxed && !as_s) begin
			rd_act = cs_s & rdds_s & wr_s;
			wr_act = cs_s & rdds_s & ~wr_s;
		end else begin
			rd_act = cs_s & ~rdds_s;
			wr_act = cs_s & ~wr_s;
		end
		rd_edge = rd_act & ~st.rd_d;
		wr_edge = ~wr_act & st.wr_d;
	end

	// ==========================================================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.rd_d   = rd_act;
		next_st.wr_d   = wr_act;
		next_st.as_d   = as_s;
		next_st.done_d = done_s;
		next_st.busy_d = busy_s;
		// Sample the strap once, only after its synchroniser has filled
		if (!st.strapped) begin
			if (st.strap_wait == STRAP_SETTLE) begin
				next_st.strapped = 1'b1;
				next_st.muxed    = ~strap_s;
			end else begin
				next_st.strap_wait = st.strap_wait + 2'h1;
			end
		end
		// Address taken from the shared bus as the strobe falls
		if (st.muxed && st.as_d && !as_s) begin
			next_st.addr = ad_s[3:0];
		end
		if (rd_edge) begin
			unique case (addr_now)
				REG_DATA_LO: next_st.rdata = rx_word[7:0];
				REG_DATA_HI: next_st.rdata = rx_word[15:8];
				REG_SELECT:  next_st.rdata = st.sel;
				REG_CLKCTL:  next_st.rdata = st.clkctl;
				REG_STATUS:  next_st.rdata = {6'h00, busy_s, st.done_flag};
				default:     next_st.rdata = 8'h00;
			endcase
			if (addr_now == REG_STATUS) begin
				next_st.done_flag = 1'b0;
			end
		end
		next_st.drive = rd_act;
		if (wr_edge && !busy_s) begin
			if (addr_now[3]) begin
				// Write through an upper slot starts a hardware-selected transfer
				next_st.dlo       = ad_s;
				next_st.hw_sel    = 1'b1;
				next_st.hw_idx    = addr_now[2:0];
				next_st.start_tgl = ~st.start_tgl;
			end else begin
				unique case (addr_now[2:0])
					3'h0: begin
						next_st.dlo       = ad_s;
						next_st.hw_sel    = 1'b0;
						next_st.start_tgl = ~st.start_tgl;
					end
					3'h1: next_st.dhi    = ad_s;
					3'h2: next_st.sel    = ad_s;
					3'h3: next_st.clkctl = ad_s;
					default: next_st.dhi = st.dhi;
				endcase
			end
		end
		// Completion flag: set wins over clear
		if (done_s != st.done_d) begin
			next_st.done_flag = 1'b1;
			next_st.hw_sel    = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge prst) begin
		if (prst) begin
			st        <= '0;
			st.sel    <= SELECT_RST;
			st.clkctl <= CLKCTL_RST;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================================
	// Pins
	always_comb begin
		cs_lines = st.sel;
		if (st.hw_sel) begin
			cs_lines = SELECT_RST & ~(8'h01 << st.hw_idx);
		end
	end

	assign shared_addr_data_bus_out = st.rdata;
	assign shared_addr_data_bus_oe  = st.drive & cs_s;
	assign lower_periph_selects     = cs_lines[3:0];
	assign lower_periph_selects_oe  = 4'hF;
	assign upper_periph_selects     = cs_lines[7:4];
	assign upper_periph_selects_oe  = {4{st.muxed}};
	assign muxed_mode               = st.muxed;
	// Interrupt drives low when enabled and a transfer is done, non-muxed only
	assign bus_format_strap_irq_out = 1'b0;
	assign bus_format_strap_irq_oe  = st.strapped & ~st.muxed
		& st.clkctl[CK_INTEN_BIT] & st.done_flag;
endmodule : sphb_port

// ==== verif/sphb_port_monitor.sv ====
// Concurrent checks on the host port pins
module sphb_port_monitor
	import sphb_pkg::*;
(
	// Clocks and reset
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       master_clock_in,
	// Host pins
	input wire logic       reset_n,
	input wire logic       dev_select_n,
	input wire logic       addr_strobe_bus_type,
	input wire logic       read_or_data_strobe,
	input wire logic       write_or_dir,
	input wire logic       shared_addr_data_bus_oe,
	input wire logic       bus_format_strap_irq_oe,
	// Serial and select pins
	input wire logic       serial_clock_out,
	input wire logic [3:0] lower_periph_selects_oe,
	input wire logic [3:0] upper_periph_selects_oe,
	input wire logic       muxed_mode
);
	logic [3:0] run_cnt;
	// Core cycles since the pin reset was last released
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst || !reset_n)
			run_cnt <= 4'h0;
		else if (run_cnt != 4'hF)
			run_cnt <= run_cnt + 4'h1;
	end
	sequence s_rd_held;
		(!muxed_mode && addr_strobe_bus_type && !dev_select_n && !read_or_data_strobe
			&& write_or_dir) [*6];
	endsequence
	sequence s_desel;
		dev_select_n [*5];
	endsequence
	a_read_answer: assert property (@(posedge core_clk) disable iff (rst)
		s_rd_held |-> shared_addr_data_bus_oe) else $error("read not answered");
	a_desel_quiet: assert property (@(posedge core_clk) disable iff (rst)
		s_desel |-> !shared_addr_data_bus_oe) else $error("bus driven while deselected");
	a_ds_idle: assert property (@(posedge core_clk) disable iff (rst)
		(!muxed_mode && !addr_strobe_bus_type && !read_or_data_strobe) [*5]
		|-> !shared_addr_data_bus_oe) else $error("bus driven without data strobe");
	a_irq_muxed: assert property (@(posedge core_clk) disable iff (rst)
		muxed_mode |-> !bus_format_strap_irq_oe) else $error("strap pin driven in muxed");
	a_upper_oe: assert property (@(posedge core_clk) disable iff (rst)
		upper_periph_selects_oe == {4{muxed_mode}}) else $error("upper select enable wrong");
	a_lower_oe: assert property (@(posedge core_clk) disable iff (rst)
		lower_periph_selects_oe == 4'hF) else $error("lower selects not driven");
	a_strap_once: assert property (@(posedge core_clk) disable iff (rst)
		run_cnt == 4'hF |-> $stable(muxed_mode)) else $error("format changed after start");
	a_sclk_pace: assert property (@(posedge master_clock_in) disable iff (rst)
		$changed(serial_clock_out) |=> $stable(serial_clock_out)) else $error("sclk too fast");
endmodule : sphb_port_monitor

bind sphb_port sphb_port_monitor sphb_port_monitor_inst (.*);

// ==== verif/sphb_periph_model.sv ====
// Behavioural serial peripheral on the link side
module sphb_periph_model (
	// Link pins
	input  wire logic        sclk,
	input  wire logic        sel_n,
	input  wire logic        sdo,
	output logic             sdi,
	// Word sent and word received
	input  wire logic [15:0] tx_word,
	output logic [15:0]      rx_word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] sh;
	logic        started;
	initial begin
		sdi = 1'b0;
		rx_word = 16'h0000;
	end
	// First bit is presented as soon as the peripheral is selected
	always @(negedge sel_n) begin
		sh = tx_word;
		sdi = tx_word[15];
		rx_word = 16'h0000;
		started = 1'b0;
	end
	always @(posedge sclk) if (!sel_n) begin
		rx_word = {rx_word[14:0], sdo};
		started = 1'b1;
	end
	always @(negedge sclk) if (!sel_n && started) begin
		sh = {sh[14:0], 1'b0};
		sdi = sh[15];
	end
	// Released line shows the inverse, not the last bit
	always @(posedge sel_n) sdi = ~sdi;
endmodule : sphb_periph_model

// ==== verif/tb.sv ====
// Self-checking bench of the host bridge port
module tb
	import sphb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, rst, master_clock_in, reset_n, dev_select_n, strap_drv, cs_n;
	logic        addr_strobe_bus_type, read_or_data_strobe, write_or_dir, muxed_mode;
	logic [3:0]  addr_in, lower_periph_selects_in, lower_periph_selects;
	logic [3:0]  lower_periph_selects_oe, upper_periph_selects, upper_periph_selects_oe;
	logic [7:0]  host_d, d, shared_addr_data_bus_in, shared_addr_data_bus_out;
	logic        shared_addr_data_bus_oe, bus_format_strap_irq_in, bus_format_strap_irq_out;
	logic        bus_format_strap_irq_oe, serial_clock_out, serial_clock_in, serial_data_in;
	logic        serial_data_out_in, serial_data_out, serial_data_out_oe;
	logic [15:0] p_tx, p_rx;
	int          n_errors = 0;
	int          compares = 0;
	int          mode = 0;
	// ==========
	// Pins seen by every party
	assign shared_addr_data_bus_in = shared_addr_data_bus_oe ? shared_addr_data_bus_out : host_d;
	assign bus_format_strap_irq_in = bus_format_strap_irq_oe ? bus_format_strap_irq_out : strap_drv;
	// The peripheral answers on the data-out line while the device has released it
	assign serial_data_out_in = serial_data_out_oe ? serial_data_out : serial_data_in;
	assign serial_clock_in = serial_clock_out;
	assign lower_periph_selects_in = lower_periph_selects;
	always #2.5 core_clk = ~core_clk;
	initial begin
		master_clock_in = 1'b0;
		#0.7;
		forever #62.5 master_clock_in = ~master_clock_in;
	end
	sphb_port sphb_port_inst (.*);
	sphb_periph_model sphb_periph_model_inst (.sclk(serial_clock_out),
		.sel_n(lower_periph_selects[0]), .sdo(serial_data_out_in), .sdi(serial_data_in),
		.tx_word(p_tx), .rx_word(p_rx));
	// ==========
	// Tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One host cycle in the current format and strobe convention
	task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] dv,
		output logic [7:0] q);
		dev_select_n = cs_n;
		addr_in = (mode == 2) ? ~a : a;
		if (mode == 2) begin
			host_d = {4'($urandom), a};
			addr_strobe_bus_type = 1'b1;
			cyc(6);
			addr_strobe_bus_type = 1'b0;
			cyc(4);
		end
		host_d = dv;
		if (mode == 1) begin
			write_or_dir = !wr;
			read_or_data_strobe = 1'b1;
		end else if (wr)
			write_or_dir = 1'b0;
		else
			read_or_data_strobe = 1'b0;
		cyc(6);
		q = shared_addr_data_bus_in;
		chk("bus_oe", shared_addr_data_bus_oe, !wr && !cs_n);
		read_or_data_strobe = (mode != 1);
		if (mode != 1)
			write_or_dir = 1'b1;
		cyc(6);
		write_or_dir = 1'b1;
		dev_select_n = 1'b1;
		cyc(4);
	endtask : acc
	task automatic wreg(input logic [3:0] a, input logic [7:0] dv);
		logic [7:0] q;
		acc(1'b1, a, dv, q);
	endtask : wreg
	task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		chk(nm, q, e);
	endtask : rchk
	function automatic logic [7:0] ctl_val(input logic ien, input logic wide, input logic soin,
		input logic [3:0] dv);
		ctl_val = {4'h0, dv};
		ctl_val[CK_INTEN_BIT] = ien;
		ctl_val[CK_WIDE_BIT] = wide;
		ctl_val[CK_SOIN_BIT] = soin;
	endfunction : ctl_val
	function automatic logic [15:0] exp_rx(input logic wide, input logic [15:0] tx);
		return wide ? tx : {8'h00, tx[15:8]};
	endfunction : exp_rx
	// Hardware-select transfer to peripheral 0, then readback
	task automatic xfer(input logic wide, input logic ien, input logic soin,
		input logic [15:0] w);
		int n;
		logic [15:0] r;
		logic [15:0] e;
		logic [7:0] q;
		logic [3:0] dv;
		realtime t0;
		p_tx = 16'($urandom);
		dv = 4'($urandom_range(3));
		wreg(REG_CLKCTL, ctl_val(ien, wide, soin, dv));
		if (wide)
			wreg(REG_DATA_HI, w[15:8]);
		wreg(REG_GO_BASE, w[7:0]);
		for (n = 0; lower_periph_selects[0] !== 1'b0 && n < 500; n++)
			cyc(1);
		chk("sel_low", lower_periph_selects[0], 1'b0);
		chk("sdo_oe", serial_data_out_oe, !soin);
		// Half period of the serial clock in link clock periods
		@(posedge serial_clock_out);
		t0 = $realtime;
		@(negedge serial_clock_out);
		chk("sclk_half", 16'(int'(($realtime - t0) / 125.0)), 16'(dv + MIN_HALF_DIV));
		for (n = 0; lower_periph_selects[0] !== 1'b1 && n < 9000; n++)
			cyc(1);
		chk("sel_high", lower_periph_selects[0], 1'b1);
		for (n = 0; bus_format_strap_irq_oe !== 1'b1 && n < 100; n++)
			cyc(1);
		chk("irq_oe", bus_format_strap_irq_oe, ien);
		r = exp_rx(wide, p_tx);
		// With data-out as input the peripheral hears its own word back
		e = soin ? r : (wide ? w : {8'h00, w[7:0]});
		chk("sent", wide ? p_rx : {8'h00, p_rx[7:0]}, e);
		rchk("rx_lo", REG_DATA_LO, r[7:0]);
		if (wide)
			rchk("rx_hi", REG_DATA_HI, r[15:8]);
		acc(1'b0, REG_STATUS, 8'h00, q);
		chk("status", q[1:0], 2'b01);
	endtask : xfer
	task automatic print_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// ==========
	// Main sequence and watchdog
	initial begin
		#400000;
		n_errors++;
		print_verdict();
	end
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		reset_n = 1'b1;
		dev_select_n = 1'b1;
		cs_n = 1'b0;
		addr_strobe_bus_type = 1'b1;
		read_or_data_strobe = 1'b1;
		write_or_dir = 1'b1;
		addr_in = 4'h0;
		host_d = 8'h00;
		strap_drv = 1'b1;
		p_tx = 16'h0000;
		void'($urandom(32'h9F18C165));
		cyc(2);
		rst = 1'b0;
		cyc(6);
		chk("muxed", muxed_mode, 1'b0);
		chk("upper_oe", upper_periph_selects_oe, 4'h0);
		chk("lower", {lower_periph_selects_oe, lower_periph_selects}, 8'hFF);
		rchk("clkctl", REG_CLKCTL, CLKCTL_RST);
		rchk("select", REG_SELECT, SELECT_RST);
		for (int i = 0; i < 3; i++) begin
			mode = i % 2;
			addr_strobe_bus_type = (mode == 0);
			read_or_data_strobe = (mode == 0);
			cyc(4);
			d = 8'($urandom);
			wreg(REG_SELECT, d);
			rchk("select_rw", REG_SELECT, d);
			chk("lower_sel", lower_periph_selects, d[3:0]);
			cs_n = 1'b1;
			wreg(REG_SELECT, ~d);
			cs_n = 1'b0;
			rchk("select_cs", REG_SELECT, d);
		end
		wreg(REG_SELECT, 8'hFF);
		for (int k = 0; k < 5; k++)
			xfer(k[0], k > 1, k == 4, 16'($urandom));
		wreg(REG_SELECT, 8'h5A);
		reset_n = 1'b0;
		cyc(4);
		reset_n = 1'b1;
		cyc(6);
		rchk("select_rst", REG_SELECT, SELECT_RST);
		strap_drv = 1'b0;
		addr_strobe_bus_type = 1'b0;
		cyc(6);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(6);
		mode = 2;
		chk("muxed", muxed_mode, 1'b1);
		chk("upper_oe", upper_periph_selects_oe, 4'hF);
		d = 8'($urandom);
		wreg(REG_SELECT, d);
		rchk("mux_rw", REG_SELECT, d);
		chk("upper_sel", upper_periph_selects, d[7:4]);
		print_verdict();
	end
endmodule : tb
